// >>> ibm_mem.sv
// Interleaved banked memory with SECDED words and fixed access latency
// Operation
// - The memory runs as 8 or 16 independent banks, chosen by configuration.
// - Each stored word is 72 bits: 64 data bits and 8 check bits.
// - Consecutive word addresses fall in consecutive banks.
// - A referenced bank stays busy four clock periods and refuses references meanwhile.
// - Read data reaches the requester eleven clock periods and one system clock after the reference while the receiver keeps up.
// - Fast destinations move at most one word per clock period.
// - Slow destinations move at most one word per two clock periods.
// - An instruction fetch delivers four words in one clock period.
// - Check bits give single-error correction and double-error detection on reads.
// - Capacity is 524,288, 1,048,576, 2,097,152 or 4,194,304 words.
// - Smaller 16-bank setups keep the full-size bank timing.
// - All memory timing counts clock periods of three 5 ns system clocks (15 ns).
// - A new request is accepted every clock period if its banks are free and no response stall or slow-destination gap holds it.
// - With 16 banks the four low address bits pick the bank.
`timescale 1ns/100ps
`include "ibm_mem_params.svh"
module ibm_mem #(
  parameter int ROWS = 16
) (
  input  wire logic                          CLK_SYS,      // 200 MHz system clock
  input  wire logic                          RESETN,       // Synchronous reset
  input  wire logic                          CFG_SIXTEEN,  // 1: sixteen banks
  input  wire logic [1:0]                    CFG_CAPACITY, // Capacity select
  input  wire logic                          REQ_VALID,    // Request offered
  input  wire ibm_mem_pkg::ibm_dest_t        REQ_DEST,     // Destination class
  input  wire logic                          REQ_WRITE,    // 1: store
  input  wire logic [`IBM_ADDR_BITS-1:0]     REQ_ADDR,     // Word address
  input  wire logic [`IBM_WORD_DATA-1:0]     REQ_WDATA,    // Store data
  output logic                               REQ_TAKEN,    // Request taken last cycle
  output logic                               RSP_VALID,    // Read data present
  input  wire logic                          RSP_READY,    // Receiver takes data
  output logic [4*`IBM_WORD_DATA-1:0]        RSP_DATA,     // Up to four words
  output logic                               RSP_FETCH,    // Four-word fetch answer
  output logic                               RSP_CORR,     // Corrected error
  output logic                               RSP_UNCORR    // Uncorrectable error
);
  import ibm_mem_pkg::*;

  localparam int CP_DIV = int'($ceil(`IBM_SYS_NS == 0.0 ? 1.0 : `IBM_CP_NS / `IBM_SYS_NS));
  localparam int BC_CP  = int'($ceil(`IBM_BANK_CYCLE_NS / `IBM_CP_NS));
  localparam int LAT_CP = int'($floor(`IBM_ACCESS_NS / `IBM_CP_NS));
  localparam int NB     = `IBM_MAX_BANKS;
  localparam int FW     = `IBM_FETCH_WORDS;
  localparam int WB     = `IBM_WORD_BITS;
  localparam int DB     = `IBM_WORD_DATA;
  localparam int RW     = $clog2(ROWS);
  localparam int DW     = $clog2(CP_DIV + 1);
  localparam int CW     = $clog2(BC_CP + 1);
  localparam int SW     = $clog2(`IBM_SLOW_GAP_CP + 1);
  localparam int BW     = FW * DB + 3;

  // ==========================================================
  // SECDED code: parity at power-of-two positions, overall in bit 0
  function automatic logic [WB-1:0] ecc_enc(input logic [DB-1:0] d);
    logic [WB-1:0] c;
    logic          par;
    int            j;
    c = '0;
    j = 0;
    for (int p = 1; p < WB; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 7; k++) begin
      par = 1'b0;
      for (int p = 1; p < WB; p++) begin
        if ((p & (1 << k)) != 0) par ^= c[p];
      end
      c[1 << k] = par;
    end
    c[0] = ^c;
    return c;
  endfunction : ecc_enc

  function automatic ibm_dec_t ecc_dec(input logic [WB-1:0] w);
    logic [WB-1:0] c;
    logic [6:0]    s;
    logic          odd;
    ibm_dec_t      r;
    int            j;
    c   = w;
    s   = '0;
    odd = ^w;
    r   = '0;
    j   = 0;
    for (int p = 1; p < WB; p++) begin
      if (c[p]) s ^= p[6:0];
    end
    if (odd) begin
      r.corr = 1'b1;
      if (s != '0 && int'(s) < WB) c[s] = ~c[s];
      else if (s != '0) r.uncorr = 1'b1;
    end else if (s != '0) begin
      r.uncorr = 1'b1;
    end
    for (int p = 1; p < WB; p++) begin
      if ((p & (p - 1)) != 0) begin
        r.data[j] = c[p];
        j++;
      end
    end
    return r;
  endfunction : ecc_dec

  // ==========================================================
  // Configuration pins and clock-period divider
  logic [2:0]    cfg1_ff, cfg2_ff, nxt_cfg1;
  logic [DW-1:0] div_ff, nxt_div;
  logic          cp_en;

  always_comb begin
    nxt_cfg1 = {CFG_SIXTEEN, CFG_CAPACITY};
    cp_en    = (div_ff == '0);
    nxt_div  = cp_en ? DW'(CP_DIV - 1) : div_ff - 1'b1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      cfg1_ff <= '0;
      cfg2_ff <= '0;
      div_ff  <= '0;
    end else begin
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= cfg1_ff;
      div_ff  <= nxt_div;
    end
  end

  // ==========================================================
  // Request decode, bank conflict check and acceptance
  logic                     sixteen, fetch, slow, free, take_w, stall;
  logic [22:0]              mask;
  logic [`IBM_ADDR_BITS-1:0] a;
  logic [3:0]               ba_w [FW];
  logic [RW-1:0]            ro_w [FW];
  logic [FW-1:0]            used;
  logic [NB-1:0]            hit_w;
  logic [CW-1:0]            busy_ff [NB];
  logic [SW-1:0]            slow_ff, nxt_slow;
  logic                     taken_ff;

  always_comb begin
    sixteen = cfg2_ff[2];
    mask    = 23'(`IBM_CAP_MIN << cfg2_ff[1:0]) - 23'h1;
    fetch   = (REQ_DEST == IBM_DEST_FETCH);
    slow    = (REQ_DEST == IBM_DEST_SLOW);
    free    = 1'b1;
    hit_w   = '0;
    a       = '0;
    for (int i = 0; i < FW; i++) begin
      a       = (REQ_ADDR + `IBM_ADDR_BITS'(i)) & mask[`IBM_ADDR_BITS-1:0];
      used[i] = (i == 0) || fetch;
      ba_w[i] = sixteen ? a[3:0] : {1'b0, a[2:0]};
      ro_w[i] = sixteen ? RW'(a >> `IBM_SEL16_SHIFT) : RW'(a >> `IBM_SEL8_SHIFT);
      if (used[i] && busy_ff[ba_w[i]] != '0) free = 1'b0;
    end
    take_w = cp_en && !stall && REQ_VALID && free
             && !(slow && slow_ff != '0);
    for (int i = 0; i < FW; i++) begin
      if (take_w && used[i]) hit_w[ba_w[i]] = 1'b1;
    end
    nxt_slow = slow_ff;
    if (take_w && slow) nxt_slow = SW'(`IBM_SLOW_GAP_CP - 1);
    else if (cp_en && slow_ff != '0) nxt_slow = slow_ff - 1'b1;
  end

  // Bank timing is the same for every size and bank count
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic [CW-1:0] nxt_busy;
    always_comb begin
      nxt_busy = busy_ff[b];
      if (hit_w[b]) nxt_busy = CW'(BC_CP - 1);
      else if (cp_en && busy_ff[b] != '0) nxt_busy = busy_ff[b] - 1'b1;
    end
    always_ff @(posedge CLK_SYS) begin
      if (!RESETN) busy_ff[b] <= '0;
      else busy_ff[b] <= nxt_busy;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      slow_ff  <= '0;
      taken_ff <= 1'b0;
    end else begin
      slow_ff  <= nxt_slow;
      taken_ff <= take_w;
    end
  end

  // ==========================================================
  // Bank storage
  logic [WB-1:0] mem_ff [NB][ROWS];
  logic [WB-1:0] nxt_mem [NB][ROWS];

  always_comb begin
    nxt_mem = mem_ff;
    if (take_w && REQ_WRITE && !fetch) begin
      nxt_mem[ba_w[0]][ro_w[0]] = ecc_enc(REQ_WDATA);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    mem_ff <= nxt_mem;
  end

  // ==========================================================
  // Access pipeline: one stage per clock period, frozen on stall
  logic [LAT_CP-1:0] pv_ff, nxt_pv;
  logic [LAT_CP-1:0] pf_ff, nxt_pf;
  logic [WB-1:0]     pd_ff [LAT_CP][FW];
  logic [WB-1:0]     nxt_pd [LAT_CP][FW];
  logic [BW-1:0]     bin;
  logic              buf_rdy, push_w, corr, unc;
  ibm_dec_t          dec;

  always_comb begin
    nxt_pv = pv_ff;
    nxt_pf = pf_ff;
    nxt_pd = pd_ff;
    stall  = pv_ff[LAT_CP-1] && !buf_rdy;
    push_w = cp_en && pv_ff[LAT_CP-1] && buf_rdy;
    if (cp_en && !stall) begin
      for (int s = LAT_CP - 1; s > 0; s--) begin
        nxt_pv[s] = pv_ff[s-1];
        nxt_pf[s] = pf_ff[s-1];
        nxt_pd[s] = pd_ff[s-1];
      end
      nxt_pv[0] = take_w && (!REQ_WRITE || fetch);
      nxt_pf[0] = fetch;
      for (int i = 0; i < FW; i++) begin
        nxt_pd[0][i] = used[i] ? mem_ff[ba_w[i]][ro_w[i]] : ecc_enc('0);
      end
    end
    corr = 1'b0;
    unc  = 1'b0;
    bin  = '0;
    for (int i = 0; i < FW; i++) begin
      dec                = ecc_dec(pd_ff[LAT_CP-1][i]);
      bin[i*DB +: DB]    = dec.data;
      corr               = corr | dec.corr;
      unc                = unc | dec.uncorr;
    end
    bin[BW-1:BW-3] = {pf_ff[LAT_CP-1], unc, corr && !unc};
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      pv_ff <= '0;
      pf_ff <= '0;
    end else begin
      pv_ff <= nxt_pv;
      pf_ff <= nxt_pf;
    end
    pd_ff <= nxt_pd;
  end

  logic [BW-1:0] bout;

  ibm_rsp_buf #(.WIDTH(BW)) u_buf (
    .clk       (CLK_SYS),
    .rst_n     (RESETN),
    .in_valid  (cp_en && pv_ff[LAT_CP-1]),
    .in_ready  (buf_rdy),
    .in_data   (bin),
    .out_valid (RSP_VALID),
    .out_ready (RSP_READY),
    .out_data  (bout)
  );

  assign REQ_TAKEN  = taken_ff;
  assign RSP_DATA   = bout[FW*DB-1:0];
  assign {RSP_FETCH, RSP_UNCORR, RSP_CORR} = bout[BW-1:BW-3];

  // ==========================================================
  // Checks
  logic [5:0]    age_ff, nxt_age;
  ibm_dec_t      chk1, chk2;
  logic [WB-1:0] cw;

  always_comb begin
    nxt_age = stall ? 6'h00 : (age_ff == 6'h3F ? age_ff : age_ff + 6'h01);
    cw      = ecc_enc(REQ_WDATA);
    chk1    = ecc_dec(cw ^ (WB'(1) << REQ_ADDR[5:0]));
    chk2    = ecc_dec(cw ^ (WB'(3) << REQ_ADDR[5:0]));
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) age_ff <= 6'h00;
    else age_ff <= nxt_age;
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence s_read_take;
    take_w && (!REQ_WRITE || fetch);
  endsequence
  sequence s_slow_take;
    take_w && slow;
  endsequence

  a_cp_period: assert property (RESETN && cp_en |=> !cp_en [*2] ##1 cp_en)
    else $error("clock period enable spacing wrong");
  a_bank_free: assert property (take_w |-> busy_ff[ba_w[0]] == '0)
    else $error("busy bank referenced");
  a_bank_hold: assert property (take_w |=>
    busy_ff[$past(ba_w[0])] == CW'(BC_CP - 1))
    else $error("bank busy count not loaded");
  a_bank_sel16: assert property (take_w && sixteen |-> ba_w[0] == REQ_ADDR[3:0])
    else $error("sixteen-bank select wrong");
  a_bank_sel8: assert property (take_w && !sixteen |->
    ba_w[0] == {1'b0, REQ_ADDR[2:0]})
    else $error("eight-bank select wrong");
  a_read_latency: assert property (s_read_take |-> ##33 (push_w || age_ff < 6'd34))
    else $error("read not delivered after eleven clock periods");
  a_slow_gap: assert property (s_slow_take |=> !(take_w && slow) [*5])
    else $error("slow destination faster than one word per two periods");
  a_fetch_four: assert property (take_w && fetch |-> $countones(hit_w) == FW)
    else $error("fetch did not reference four banks");
  a_ecc_single: assert property (chk1.data == REQ_WDATA
    && chk1.corr && !chk1.uncorr)
    else $error("single-bit error not corrected");
  a_ecc_double: assert property (chk2.uncorr)
    else $error("double-bit error not detected");
  a_stall_block: assert property (stall |-> !take_w ##1 pv_ff[LAT_CP-1])
    else $error("request taken or data lost during stall");
endmodule : ibm_mem

// >>> ibm_mem_params.svh
// Constants for the interleaved banked memory
`ifndef IBM_MEM_PARAMS_SVH
`define IBM_MEM_PARAMS_SVH

// Timing, in nanoseconds
`define IBM_SYS_NS        5.0
`define IBM_CP_NS         12.5
`define IBM_BANK_CYCLE_NS 50.0
`define IBM_ACCESS_NS     137.5

// Word and bank layout
`define IBM_WORD_DATA     64
`define IBM_WORD_CHECK    8
`define IBM_WORD_BITS     72
`define IBM_ADDR_BITS     22
`define IBM_MAX_BANKS     16
`define IBM_SEL16_SHIFT   4
`define IBM_SEL8_SHIFT    3
`define IBM_FETCH_WORDS   4
`define IBM_SLOW_GAP_CP   2
`define IBM_CAP_MIN       23'h08_0000

`endif

// >>> ibm_mem_pkg.sv
// Types shared by the interleaved banked memory
`include "ibm_mem_params.svh"
package ibm_mem_pkg;
  typedef enum logic [1:0] {IBM_DEST_FAST, IBM_DEST_SLOW, IBM_DEST_FETCH} ibm_dest_t;
  typedef struct packed {
    logic [`IBM_WORD_DATA-1:0] data;
    logic                      corr;
    logic                      uncorr;
  } ibm_dec_t;
endpackage : ibm_mem_pkg

// >>> ibm_mem_test.sv
// Self-checking bench for the interleaved banked memory
`timescale 1ns/100ps
`include "ibm_mem_params.svh"
module ibm_mem_test;
  import ibm_mem_pkg::*;
  logic                        clk_sys;
  logic                        resetn;
  logic                        cfg_sixteen;
  logic [1:0]                  cfg_capacity;
  ibm_dest_t                   req_dest;
  logic                        req_valid;
  logic                        req_write;
  logic [`IBM_ADDR_BITS-1:0]   req_addr;
  logic [`IBM_WORD_DATA-1:0]   req_wdata;
  logic                        req_taken;
  logic                        rsp_valid;
  logic                        rsp_ready;
  logic [4*`IBM_WORD_DATA-1:0] rsp_data;
  logic                        rsp_fetch;
  logic                        rsp_corr;
  logic                        rsp_uncorr;
  int                          n_mismatch = 0;
  int                          total_checks = 0;
  int                          cyc = 0;
  int                          lat_on = 1;
  int                          n_ops = 0;
  int                          takes[$];
  int                          rd_take[$];
  logic [255:0]                exp_q[$];
  logic                        exp_f[$];
  logic [63:0]                 mem[int];

  ibm_mem DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG_SIXTEEN(cfg_sixteen),
    .CFG_CAPACITY(cfg_capacity), .REQ_VALID(req_valid), .REQ_DEST(req_dest),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_TAKEN(req_taken), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready),
    .RSP_DATA(rsp_data), .RSP_FETCH(rsp_fetch), .RSP_CORR(rsp_corr),
    .RSP_UNCORR(rsp_uncorr));
  ibm_req_model req (.clk(clk_sys), .req_dest(req_dest), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_taken(req_taken), .rsp_ready(rsp_ready));

  // ==========
  // Checking and closing
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ==========
  // Reference model: word store and expected answers in order
  task automatic op(input ibm_dest_t d, input logic w, input int a, input logic [63:0] wd);
    logic [255:0] e;
    int           m;
    m = (1 << (19 + cfg_capacity)) - 1;
    e = '0;
    if (w && d != IBM_DEST_FETCH) begin
      mem[a & m] = wd;
    end else begin
      for (int i = 0; i < (d == IBM_DEST_FETCH ? 4 : 1); i++) e[64*i +: 64] = mem[(a + i) & m];
      exp_q.push_back(e);
      exp_f.push_back(d == IBM_DEST_FETCH);
    end
    n_ops++;
    req.issue(d, w, 22'(a), wd);
  endtask : op
  task automatic pair(input ibm_dest_t d, input int a, input int b, input int gap);
    int t0;
    t0 = takes.size();
    op(d, 1'b0, a, 64'h0);
    op(d, 1'b0, b, 64'h0);
    @(posedge clk_sys);
    check(256'(takes[t0+1] - takes[t0]), 256'(gap));
  endtask : pair
  task automatic drain;
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    check(256'(exp_q.size()), 256'd0);
    check(256'(takes.size()), 256'(n_ops));
  endtask : drain

  // ==========
  // Monitor: take times, answers and latency
  always @(posedge clk_sys) begin
    cyc++;
    if (req_taken === 1'b1) begin
      takes.push_back(cyc - 1);
      if (req_write !== 1'b1 || req_dest == IBM_DEST_FETCH) rd_take.push_back(cyc - 1);
    end
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      check(rsp_data, exp_q.pop_front());
      check(256'(rsp_fetch), 256'(exp_f.pop_front()));
      check(256'({rsp_corr, rsp_uncorr}), 256'd0);
      if (lat_on != 0) check(256'(cyc - rd_take.pop_front()), 256'd34);
      else void'(rd_take.pop_front());
    end
  end

  // ==========
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    int a;
    resetn       = 1'b0;
    cfg_sixteen  = 1'b1;
    cfg_capacity = 2'd3;
    void'($urandom(53344));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 64; i++) begin
      op(IBM_DEST_FAST, 1'b1, i, {$urandom, $urandom});
    end
    repeat (12) @(posedge clk_sys);
    pair(IBM_DEST_FAST, 0, 1, 3);
    pair(IBM_DEST_FAST, 2, 18, 12);
    pair(IBM_DEST_FAST, 20, 28, 3);
    pair(IBM_DEST_SLOW, 33, 34, 6);
    pair(IBM_DEST_FETCH, 40, 43, 12);
    pair(IBM_DEST_FAST, 50, 51, 3);
    drain();
    lat_on = 0;
    req.rdy_mode = 1;
    fork
      for (int i = 0; i < 5; i++) op(IBM_DEST_FAST, 1'b0, 4 * i + 1, 64'h0);
      begin
        repeat (90) @(posedge clk_sys);
        req.rdy_mode = 2;
      end
    join
    for (int i = 0; i < 60; i++) begin
      a = $urandom % 60;
      op(ibm_dest_t'($urandom % 3), 1'($urandom), a, {$urandom, $urandom});
    end
    drain();
    req.rdy_mode = 0;
    repeat (4) @(posedge clk_sys);
    lat_on = 1;
    cfg_sixteen <= 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 16; i++) op(IBM_DEST_FAST, 1'b1, i, {$urandom, $urandom});
    repeat (12) @(posedge clk_sys);
    pair(IBM_DEST_FAST, 0, 8, 12);
    pair(IBM_DEST_FAST, 9, 10, 3);
    // Smallest capacity: the address bit above it aliases to the low word
    cfg_capacity <= 2'd0;
    repeat (10) @(posedge clk_sys);
    op(IBM_DEST_FAST, 1'b1, 'h80005, {$urandom, $urandom});
    op(IBM_DEST_FAST, 1'b0, 5, 64'h0);
    drain();
    report_and_stop();
  end
endmodule : ibm_mem_test

// >>> ibm_req_model.sv
// Requester and receiver model on the far side of the memory port
`timescale 1ns/100ps
`include "ibm_mem_params.svh"
module ibm_req_model (
  input  wire logic                 clk,       // System clock
  output ibm_mem_pkg::ibm_dest_t    req_dest,  // Destination class
  output logic                      req_valid, // Request offered
  output logic                      req_write, // Store
  output logic [`IBM_ADDR_BITS-1:0] req_addr,  // Word address
  output logic [`IBM_WORD_DATA-1:0] req_wdata, // Store data
  input  wire logic                 req_taken, // Taken pulse
  output logic                      rsp_ready  // Takes head word
);
  import ibm_mem_pkg::*;
  int rdy_mode = 0;
  initial begin
    req_dest  = IBM_DEST_FAST;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = '0;
    req_wdata = '0;
    rsp_ready = 1'b1;
  end
  // ==========
  // Request held until taken or for at most 400 cycles, then address and data inverted so stale values never look valid
  task automatic issue(input ibm_dest_t d, input logic w,
                       input logic [`IBM_ADDR_BITS-1:0] a, input logic [`IBM_WORD_DATA-1:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req_dest  <= d;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (req_taken !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_wdata <= ~wd;
  endtask : issue
  // ==========
  // Receiver: always, never or randomly ready
  always @(posedge clk) begin
    case (rdy_mode)
      0: rsp_ready <= 1'b1;
      1: rsp_ready <= 1'b0;
      default: rsp_ready <= ($urandom % 3) != 0;
    endcase
  end
endmodule : ibm_req_model

// >>> ibm_rsp_buf.sv
// Two-entry response buffer with valid and ready on both sides
`timescale 1ns/100ps
module ibm_rsp_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst_n,     // Synchronous reset, active low
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Offered word
  output logic                  out_valid, // Head word present
  input  wire logic             out_ready, // Receiver takes head
  output logic [WIDTH-1:0]      out_data   // Head word
);
  logic [1:0]       val_ff;
  logic [1:0]       nxt_val;
  logic [WIDTH-1:0] buf_ff [2];
  logic [WIDTH-1:0] nxt_buf [2];
  logic             push;
  logic             pop;

  // ==========================================================
  // Slot 0 is always the head; slot 1 fills when head stalls
  always_comb begin
    push    = in_valid && !val_ff[1];
    pop     = val_ff[0] && out_ready;
    nxt_val = val_ff;
    nxt_buf = buf_ff;
    if (pop) begin
      nxt_val[0] = val_ff[1];
      nxt_buf[0] = buf_ff[1];
      nxt_val[1] = 1'b0;
    end
    if (push) begin
      if (!nxt_val[0]) begin
        nxt_val[0] = 1'b1;
        nxt_buf[0] = in_data;
      end else begin
        nxt_val[1] = 1'b1;
        nxt_buf[1] = in_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      val_ff    <= '0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
    end else begin
      val_ff <= nxt_val;
      buf_ff <= nxt_buf;
    end
  end

  assign in_ready  = !val_ff[1];
  assign out_valid = val_ff[0];
  assign out_data  = buf_ff[0];
endmodule : ibm_rsp_buf
